// >>> hw/ca_regs.svh
// Offsets, field positions, reset values and timing counts for the counter array.
// Assumes an 8-bit special-function register port with one-cycle read and write strobes.
// Behaviour
// [RULE1] A qualified capture edge copies the 16-bit counter into that module's capture pair.
// [RULE2] Rise and fall select bits qualify edges; both set means either edge captures.
// [RULE3] Each capture sets the module flag; interrupt only if its flag interrupt is enabled.
// [RULE4] Flags are never cleared by interrupt entry, only by software writing zero.
// [RULE5] With both edge selects set, the capture pin level stays readable by software.
// [RULE6] A capture input level is valid only after two system clocks; shorter pulses ignored.
// [RULE7] Mode bit 7 clear keeps counting in CPU idle; set suspends the counter.
// [RULE8] Mode bit 6 enables watchdog; bit 5 locks that enable until the next reset.
// [RULE9] Mode bits 3..1 select the count source from six choices; two codes reserved.
// [RULE10] Mode bit 0 masks the overflow flag interrupt request.
// [RULE11] External count inputs are synchronised; external edges count at most sysclk/4.
`ifndef CA_REGS_SVH
`define CA_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define CA_ADDR_CONTROL   8'hD8
`define CA_ADDR_MODE      8'hD9
`define CA_ADDR_MODREG0   8'hDA
`define CA_ADDR_PINLEVEL  8'hDF
`define CA_ADDR_COUNT_LO  8'hE8
`define CA_ADDR_CAP_LO0   8'hE9
`define CA_ADDR_COUNT_HI  8'hF8
`define CA_ADDR_CAP_HI0   8'hF9

// ****************************************
// Field positions
// ****************************************
`define CA_MODE_IDLE_BIT  7
`define CA_MODE_WDE_BIT   6
`define CA_MODE_LOCK_BIT  5
`define CA_MODE_SRC_HI    3
`define CA_MODE_SRC_LO    1
`define CA_MODE_OVIE_BIT  0
`define CA_CTL_OVF_BIT    7
`define CA_CTL_RUN_BIT    6
`define CA_MOD_RISE_BIT   5
`define CA_MOD_FALL_BIT   4
`define CA_MOD_IE_BIT     0

// ****************************************
// Reset values and timing
// ****************************************
`define CA_MODE_RESET     8'h40
`define CA_MODES          5
`define CA_DIV_SLOW       4'hB
`define CA_EXT_GAP        2'h3
`define CA_OSC_DIV        3'h7

`endif

// >>> hw/ca_pkg.sv
// Types shared by the counter array files.
// Assumes nothing beyond the register header.
package ca_pkg;

	// Count source codes, in register order
	typedef enum logic [2:0] {
		CA_SRC_DIV12,
		CA_SRC_DIV4,
		CA_SRC_TIMER0,
		CA_SRC_EXT_FALL,
		CA_SRC_SYSCLK,
		CA_SRC_OSC_DIV8,
		CA_SRC_RSVD6,
		CA_SRC_RSVD7
	} ca_src_t;

endpackage

// >>> hw/ca_capture_chan.sv
// One edge-triggered capture module: pin filter, edge qualify, capture register.
// Assumes the pin is asynchronous to clk and the counter value is on clk.
`timescale 1ns/1ps
module ca_capture_chan
	import ca_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        ce,
	// Pin and configuration
	input  wire logic        pin_in,
	input  wire logic        rise_sel,
	input  wire logic        fall_sel,
	input  wire logic [15:0] count_value,
	// Results
	output logic             captured,
	output logic      [15:0] cap_value,
	output logic             level
);

	logic [2:0] sync;
	logic       agree;
	logic       rise;
	logic       fall;

	// ****************************************
	// Pin filter
	// ****************************************
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sync <= 3'h0;
		end else if (ce) begin
			sync <= {sync[1:0], pin_in};
		end
	end

	// [RULE6] Two-cycle validity
	assign agree = (sync[1] == sync[2]);
	assign rise  = agree && sync[2] && !level;
	assign fall  = agree && !sync[2] && level;

	// [RULE5] Filtered level kept
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			level <= 1'b0;
		end else if (ce && agree) begin
			level <= sync[2];
		end
	end

	// ****************************************
	// Capture
	// ****************************************
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			captured  <= 1'b0;
			cap_value <= 16'h0000;
		end else if (ce) begin
			// [RULE2] Edge qualify
			captured <= (rise && rise_sel) || (fall && fall_sel);
			// [RULE1] Latch counter
			if ((rise && rise_sel) || (fall && fall_sel)) begin
				cap_value <= count_value;
			end
		end
	end

endmodule

// >>> hw/ca_counter_array.sv
// Counter array timebase with five edge-triggered capture modules.
// Assumes an 8-bit register port with one-cycle strobes on clk; timer0_ovf is on clk.
`timescale 1ns/1ps
`include "ca_regs.svh"
module ca_counter_array
	import ca_pkg::*;
(
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire logic                  ce,
	// Register port
	input  wire logic            [7:0] reg_addr,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	input  wire logic            [7:0] reg_wdata,
	output logic                 [7:0] reg_rdata,
	// System inputs
	input  wire logic                  cpu_idle,
	input  wire logic                  timer0_ovf,
	input  wire logic                  external_count_input,
	input  wire logic                  ext_osc_clk,
	input  wire logic [`CA_MODES-1:0]  capture_input_n,
	// Outputs
	output logic                       irq,
	output logic                       watchdog_enable
);

	logic                 idle_suspend;
	logic                 watchdog_enable_lock;
	ca_src_t              count_source_select;
	logic                 overflow_irq_enable;
	logic                 overflow_flag;
	logic                 counter_run;
	logic [`CA_MODES-1:0] capture_flag_n;
	logic [`CA_MODES-1:0] rise_edge_select_n;
	logic [`CA_MODES-1:0] fall_edge_select_n;
	logic [`CA_MODES-1:0] flag_irq_en;
	logic [`CA_MODES-1:0] captured;
	logic [`CA_MODES-1:0] pin_level;
	logic [15:0]          cap_value [`CA_MODES];
	logic [15:0]          count;
	logic [3:0]           div_cnt;
	logic [2:0]           osc_cnt;
	logic [1:0]           ext_gap;
	logic [2:0]           ext_sync [2];
	logic [1:0]           ext_level;
	logic [1:0]           ext_agree;
	logic                 tick;
	logic                 step;
	logic                 ext_fall;
	logic                 osc_rise;
	logic [7:0]           next_rdata;

	// Reset image of the mode register; a bare literal cannot be bit-selected
	localparam logic [7:0] mode_reset = `CA_MODE_RESET;

	// ****************************************
	// External count inputs
	// ****************************************
	// [RULE11] Synchronise and filter
	for (genvar i = 0; i < 2; i++) begin : g_ext
		always_ff @(posedge clk or posedge reset) begin
			if (reset) begin
				ext_sync[i]  <= 3'h0;
				ext_level[i] <= 1'b0;
			end else if (ce) begin
				ext_sync[i] <= {ext_sync[i][1:0], (i == 0) ? external_count_input : ext_osc_clk};
				if (ext_agree[i]) begin
					ext_level[i] <= ext_sync[i][2];
				end
			end
		end
		assign ext_agree[i] = (ext_sync[i][1] == ext_sync[i][2]);
	end

	assign ext_fall = ext_agree[0] && !ext_sync[0][2] && ext_level[0];
	assign osc_rise = ext_agree[1] && ext_sync[1][2] && !ext_level[1];

	// ****************************************
	// Prescalers
	// ****************************************
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			div_cnt <= 4'h0;
		end else if (ce) begin
			div_cnt <= (div_cnt == `CA_DIV_SLOW) ? 4'h0 : div_cnt + 4'h1;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			osc_cnt <= 3'h0;
		end else if (ce && osc_rise) begin
			osc_cnt <= osc_cnt + 3'h1;
		end
	end

	// [RULE11] Edges closer than four clocks are dropped, capping the rate at sysclk/4
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ext_gap <= 2'h0;
		end else if (ce) begin
			if (ext_fall && ext_gap == 2'h0) begin
				ext_gap <= `CA_EXT_GAP;
			end else if (ext_gap != 2'h0) begin
				ext_gap <= ext_gap - 2'h1;
			end
		end
	end

	// [RULE9] Source select
	always_comb begin
		case (count_source_select)
			CA_SRC_DIV12:    tick = (div_cnt == `CA_DIV_SLOW);
			CA_SRC_DIV4:     tick = (div_cnt[1:0] == 2'h3);
			CA_SRC_TIMER0:   tick = timer0_ovf;
			CA_SRC_EXT_FALL: tick = ext_fall && (ext_gap == 2'h0);
			CA_SRC_SYSCLK:   tick = 1'b1;
			CA_SRC_OSC_DIV8: tick = osc_rise && (osc_cnt == `CA_OSC_DIV);
			default:         tick = 1'b0;
		endcase
	end

	// [RULE7] Idle suspend
	assign step = counter_run && tick && !(idle_suspend && cpu_idle);

	// ****************************************
	// Counter
	// ****************************************
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			count <= 16'h0000;
		end else if (ce) begin
			if (reg_wr && reg_addr == `CA_ADDR_COUNT_LO) begin
				count[7:0] <= reg_wdata;
			end else if (reg_wr && reg_addr == `CA_ADDR_COUNT_HI) begin
				count[15:8] <= reg_wdata;
			end else if (step) begin
				count <= count + 16'h0001;
			end
		end
	end

	// ****************************************
	// Mode register
	// ****************************************
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			idle_suspend         <= mode_reset[`CA_MODE_IDLE_BIT];
			watchdog_enable      <= mode_reset[`CA_MODE_WDE_BIT];
			watchdog_enable_lock <= mode_reset[`CA_MODE_LOCK_BIT];
			count_source_select  <= ca_src_t'(mode_reset[`CA_MODE_SRC_HI:`CA_MODE_SRC_LO]);
			overflow_irq_enable  <= mode_reset[`CA_MODE_OVIE_BIT];
		end else if (ce && reg_wr && reg_addr == `CA_ADDR_MODE) begin
			idle_suspend        <= reg_wdata[`CA_MODE_IDLE_BIT];
			count_source_select <= ca_src_t'(reg_wdata[`CA_MODE_SRC_HI:`CA_MODE_SRC_LO]);
			overflow_irq_enable <= reg_wdata[`CA_MODE_OVIE_BIT];
			// [RULE8] Lock is sticky until reset
			if (!watchdog_enable_lock) begin
				watchdog_enable      <= reg_wdata[`CA_MODE_WDE_BIT];
				watchdog_enable_lock <= reg_wdata[`CA_MODE_LOCK_BIT];
			end
		end
	end

	// ****************************************
	// Capture modules
	// ****************************************
	for (genvar n = 0; n < `CA_MODES; n++) begin : g_mod
		always_ff @(posedge clk or posedge reset) begin
			if (reset) begin
				rise_edge_select_n[n] <= 1'b0;
				fall_edge_select_n[n] <= 1'b0;
				flag_irq_en[n]        <= 1'b0;
			end else if (ce && reg_wr && reg_addr == `CA_ADDR_MODREG0 + 8'(n)) begin
				rise_edge_select_n[n] <= reg_wdata[`CA_MOD_RISE_BIT];
				fall_edge_select_n[n] <= reg_wdata[`CA_MOD_FALL_BIT];
				flag_irq_en[n]        <= reg_wdata[`CA_MOD_IE_BIT];
			end
		end

		// [RULE3] Set beats software clear
		// [RULE4] Cleared by software only
		always_ff @(posedge clk or posedge reset) begin
			if (reset) begin
				capture_flag_n[n] <= 1'b0;
			end else if (ce) begin
				if (captured[n]) begin
					capture_flag_n[n] <= 1'b1;
				end else if (reg_wr && reg_addr == `CA_ADDR_CONTROL) begin
					capture_flag_n[n] <= reg_wdata[n];
				end
			end
		end

		ca_capture_chan u_chan (
			.clk         (clk),
			.reset       (reset),
			.ce          (ce),
			.pin_in      (capture_input_n[n]),
			.rise_sel    (rise_edge_select_n[n]),
			.fall_sel    (fall_edge_select_n[n]),
			.count_value (count),
			.captured    (captured[n]),
			.cap_value   (cap_value[n]),
			.level       (pin_level[n])
		);
	end

	// ****************************************
	// Control register
	// ****************************************
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			overflow_flag <= 1'b0;
			counter_run   <= 1'b0;
		end else if (ce) begin
			if (reg_wr && reg_addr == `CA_ADDR_CONTROL) begin
				counter_run <= reg_wdata[`CA_CTL_RUN_BIT];
			end
			// Overflow set wins over a same-cycle clear
			if (step && count == 16'hFFFF) begin
				overflow_flag <= 1'b1;
			end else if (reg_wr && reg_addr == `CA_ADDR_CONTROL) begin
				overflow_flag <= reg_wdata[`CA_CTL_OVF_BIT];
			end
		end
	end

	// [RULE10] Overflow mask
	// [RULE3] Flag interrupt gating
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			irq <= 1'b0;
		end else if (ce) begin
			irq <= (overflow_flag && overflow_irq_enable) || |(capture_flag_n & flag_irq_en);
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	always_comb begin
		next_rdata = 8'h00;
		if (reg_addr == `CA_ADDR_CONTROL) begin
			next_rdata = {overflow_flag, counter_run, 1'b0, capture_flag_n};
		end else if (reg_addr == `CA_ADDR_MODE) begin
			next_rdata = {idle_suspend, watchdog_enable, watchdog_enable_lock, 1'b0,
				count_source_select, overflow_irq_enable};
		end else if (reg_addr == `CA_ADDR_PINLEVEL) begin
			// [RULE5] Pin level readable
			next_rdata = {3'h0, pin_level};
		end else if (reg_addr == `CA_ADDR_COUNT_LO) begin
			next_rdata = count[7:0];
		end else if (reg_addr == `CA_ADDR_COUNT_HI) begin
			next_rdata = count[15:8];
		end else begin
			for (int k = 0; k < `CA_MODES; k++) begin
				if (reg_addr == `CA_ADDR_MODREG0 + 8'(k)) begin
					next_rdata = {2'h0, rise_edge_select_n[k], fall_edge_select_n[k],
						3'h0, flag_irq_en[k]};
				end else if (reg_addr == `CA_ADDR_CAP_LO0 + 8'(k)) begin
					next_rdata = cap_value[k][7:0];
				end else if (reg_addr == `CA_ADDR_CAP_HI0 + 8'(k)) begin
					next_rdata = cap_value[k][15:8];
				end
			end
		end
	end

	// Read data is held between reads so a slow reader sees a stable byte
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			reg_rdata <= 8'h00;
		end else if (ce && reg_rd) begin
			reg_rdata <= next_rdata;
		end
	end

endmodule

// >>> sim/ca_pin_source.sv
// Model of the external sources on the five capture pins.
// Assumes the bench calls drive(); pins change on the falling edge.
`timescale 1ns/1ps
module ca_pin_source (
	// Clock
	input  wire logic       clk,
	// Pins
	output logic      [4:0] pins
);
	initial pins = 5'h00;
	task automatic drive(input logic [4:0] v, input int hold);
		@(negedge clk);
		pins = v;
		repeat (hold) @(negedge clk);
	endtask
endmodule

// >>> sim/ca_counter_array_monitor.sv
// Checker for the counter array register port and outputs.
// Assumes it is bound to ca_counter_array and sees only its ports.
`timescale 1ns/1ps
module ca_monitor (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       ce,
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       cpu_idle,
	input  wire logic [4:0] capture_input_n,
	input  wire logic       irq,
	input  wire logic       watchdog_enable
);
	logic locked;
	logic idle_sus;
	wire  mode_wr = ce && reg_wr && reg_addr == 8'hD9;
	wire  any_wr  = ce && reg_wr;
	// Shadow of the mode bits the checks depend on
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			locked   <= 1'b0;
			idle_sus <= 1'b0;
		end else if (mode_wr) begin
			locked   <= locked | reg_wdata[5];
			idle_sus <= reg_wdata[7];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_rd(logic [7:0] ad);
		ce && reg_rd && !reg_wr && reg_addr == ad;
	endsequence
	sequence s_frozen;
		(idle_sus && cpu_idle)[*3] ##0 s_rd(8'hE8) ##1 (idle_sus && cpu_idle) ##1 s_rd(8'hE8);
	endsequence
	AST_RDATA_STANDS: assert property (!(ce && reg_rd) |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	AST_WDE_WRITE: assert property (mode_wr && !locked |=> watchdog_enable == $past(reg_wdata[6]))
		else $error("watchdog enable missed a write");
	AST_WDE_LOCKED: assert property (locked |=> $stable(watchdog_enable))
		else $error("watchdog enable changed while locked");
	AST_WDE_NO_WRITE: assert property (!mode_wr |=> $stable(watchdog_enable))
		else $error("watchdog enable changed on its own");
	AST_MODE_READBACK: assert property (s_rd(8'hD9) |=> reg_rdata[6] == watchdog_enable && reg_rdata[5] == locked)
		else $error("mode readback wrong");
	AST_IRQ_SW_CLEAR: assert property ($fell(irq) |-> $past(any_wr) || $past(any_wr, 2) || $past(any_wr, 3))
		else $error("interrupt dropped without a write");
	AST_IDLE_FREEZE: assert property (s_frozen |=> reg_rdata == $past(reg_rdata, 2))
		else $error("counter moved while suspended");
	AST_PIN_LEVEL: assert property ($stable(capture_input_n)[*5] ##0 s_rd(8'hDF) |=> reg_rdata[4:0] == $past(capture_input_n))
		else $error("pin level read wrong");
endmodule
bind ca_counter_array ca_monitor i_mon (.clk, .reset, .ce, .reg_addr, .reg_wr, .reg_rd,
	.reg_wdata, .reg_rdata, .cpu_idle, .capture_input_n, .irq, .watchdog_enable);

// >>> sim/testbench.sv
// Bench for the counter array: register port, capture pins, count sources.
// Assumes the pin source model and bound checker are compiled alongside.
`timescale 1ns/1ps
module testbench;
	logic        clk, reset, ce, reg_wr, reg_rd, cpu_idle, t0, ext_in, osc, irq, wde;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, d, a, b;
	logic [4:0]  pins;
	logic [15:0] cap [5] = '{default: 16'h0000};
	int          err_total, n_compared;
	// Modes: rise, fall, both, none, rise without interrupt
	logic [7:0]  mm [5] = '{8'h21, 8'h11, 8'h31, 8'h01, 8'h20};
	// Counts over 72 clocks per source code
	logic [7:0]  stp [8] = '{8'h06, 8'h12, 8'h08, 8'h08, 8'h48, 8'h02, 8'h00, 8'h00};

	ca_counter_array i_dut (.clk, .reset, .ce, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
		.reg_rdata, .cpu_idle, .timer0_ovf(t0), .external_count_input(ext_in),
		.ext_osc_clk(osc), .capture_input_n(pins), .irq, .watchdog_enable(wde));
	ca_pin_source i_src (.clk, .pins);

	// ****
	// Tasks
	// ****
	task automatic chk(input string what, input logic [7:0] exp, got);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] ad, dt);
		@(negedge clk);
		reg_addr  = ad;
		reg_wdata = dt;
		reg_wr    = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] ad, output logic [7:0] dt);
		@(negedge clk);
		reg_addr = ad;
		reg_rd   = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		dt     = reg_rdata;
	endtask
	task automatic rc(input logic [7:0] ad, exp, input string what);
		rd(ad, d);
		chk(what, exp, d);
	endtask
	task automatic caps(input logic [4:0] m, input logic [15:0] v);
		for (int n = 0; n < 5; n++) begin
			if (m[n])
				cap[n] = v;
			rc(8'hE9 + 8'(n), cap[n][7:0], "cap low");
			rc(8'hF9 + 8'(n), cap[n][15:8], "cap high");
		end
	endtask
	task automatic step2(input logic [7:0] exp);
		rd(8'hE8, a);
		rd(8'hE8, b);
		chk("count", exp, b - a);
	endtask
	// Every source is stirred; only the selected one may count
	task automatic window(input logic [2:0] src, input logic [7:0] exp);
		wr(8'hD9, {4'h4, src, 1'b0});
		rd(8'hE8, a);
		for (int i = 0; i < 70; i++) begin
			@(negedge clk);
			t0     = i % 8 == 0 && i < 64;
			ext_in = i % 8 > 3 || i >= 64;
			osc    = i % 4 < 2 && i < 64;
		end
		rd(8'hE8, b);
		chk("source count", exp, b - a);
	endtask
	task automatic summarize();
		if (err_total == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ****
	// Clock, watchdog, tests
	// ****
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		#40000;
		err_total++;
		summarize();
	end
	initial begin
		reset = 1'b1;
		{reg_wr, reg_rd, cpu_idle, t0, osc} = 5'h00;
		ce        = 1'b1;
		ext_in    = 1'b1;
		reg_addr  = 8'h00;
		reg_wdata = 8'h00;
		err_total  = 0;
		n_compared = 0;
		repeat (12) @(negedge clk);
		reset = 1'b0;
		chk("wde", 8'h01, {7'h00, wde});
		rc(8'hD9, 8'h40, "mode");
		rc(8'h00, 8'h00, "unmapped");
		for (int n = 0; n < 5; n++)
			wr(8'hDA + 8'(n), mm[n]);
		wr(8'hE8, 8'h57);
		wr(8'hF8, 8'h13);
		i_src.drive(5'h1F, 5);
		rc(8'hD8, 8'h15, "flags");
		caps(5'h15, 16'h1357);
		chk("irq", 8'h01, {7'h00, irq});
		rc(8'hD8, 8'h15, "flags");
		rc(8'hDF, 8'h1F, "pins");
		wr(8'hD8, 8'h00);
		wr(8'hE8, 8'h68);
		wr(8'hF8, 8'h24);
		i_src.drive(5'h00, 5);
		rc(8'hD8, 8'h06, "flags");
		caps(5'h06, 16'h2468);
		wr(8'hD8, 8'h00);
		i_src.drive(5'h10, 5);
		rc(8'hD8, 8'h10, "flags");
		chk("irq", 8'h00, {7'h00, irq});
		wr(8'hD8, 8'h00);
		i_src.drive(5'h11, 0);
		i_src.drive(5'h10, 5);
		rc(8'hD8, 8'h00, "flags");
		i_src.drive(5'h11, 1);
		i_src.drive(5'h10, 5);
		rc(8'hD8, 8'h01, "flags");
		wr(8'hD8, 8'h00);
		wr(8'hE8, 8'hF0);
		wr(8'hF8, 8'hFF);
		wr(8'hD9, 8'h48);
		wr(8'hD8, 8'h40);
		repeat (30) @(negedge clk);
		chk("irq", 8'h00, {7'h00, irq});
		rc(8'hD8, 8'hC0, "control");
		wr(8'hD9, 8'h49);
		repeat (2) @(negedge clk);
		chk("irq", 8'h01, {7'h00, irq});
		wr(8'hD8, 8'h40);
		wr(8'hD9, 8'hC8);
		cpu_idle = 1'b1;
		repeat (3) @(negedge clk);
		step2(8'h00);
		wr(8'hD9, 8'h48);
		step2(8'h02);
		// Clock enable low for ten edges must hold the counter still
		rd(8'hE8, a);
		ce = 1'b0;
		repeat (10) @(negedge clk);
		ce = 1'b1;
		rd(8'hE8, b);
		chk("frozen count", 8'h02, b - a);
		cpu_idle = 1'b0;
		for (int c = 0; c < 8; c++)
			window(3'(c), stp[c]);
		wr(8'hD9, 8'h00);
		chk("wde", 8'h00, {7'h00, wde});
		wr(8'hD9, 8'h60);
		wr(8'hD9, 8'h00);
		chk("wde", 8'h01, {7'h00, wde});
		rc(8'hD9, 8'h60, "mode");
		summarize();
	end
endmodule
